// [logic/fcs_regs.vh]
// Constants for the configuration/status/protection command block
// Included by fcs_nv_cfg and fcs_cmd; definitions only
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
`define FCS_OP_READ_CFG 8'h3f
`define FCS_OP_ACTIVE_STATUS 8'h25
`define FCS_SEQ_B1 8'h3d
`define FCS_SEQ_B2 8'h2a
`define FCS_SEQ_CFG 8'h81
`define FCS_SEQ_QUAD_ON 8'h66
`define FCS_SEQ_QUAD_OFF 8'h67
`define FCS_SEQ_PROT 8'h7f
`define FCS_SEQ_PROT_ON 8'ha9
`define FCS_SEQ_PROT_OFF 8'h9a
`define FCS_CFG_QE_BIT 7
`define FCS_CFG_FIXED 8'h08
`define FCS_CFG_FIXED_MASK 8'h7f
`define FCS_QE_SHIPPED 1'b0
`define FCS_T_WRCR_US 1
`define FCS_CLK_MHZ 25
`define FCS_WRCR_CYCLES (`FCS_T_WRCR_US * `FCS_CLK_MHZ)
`endif

// [logic/fcs_sync.v]
// Two-flop synchroniser for one level from outside the ref_clk domain
// Assumes the input may change at any time relative to ref_clk
`timescale 1ns/1ns
module fcs_sync #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Level in and out
  input wire async_in,
  output reg sync_out
);
  reg stage1;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// [logic/fcs_nv_cfg.v]
// Nonvolatile configuration bit store with internally timed programming
// Assumes nv_init carries the stored value from the array at power-up
`timescale 1ns/1ns
`include "fcs_regs.vh"
module fcs_nv_cfg #(
  parameter WRCR_CYCLES = `FCS_WRCR_CYCLES
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Stored value restored after reset
  input wire nv_init,
  // Program request
  input wire prog_start,
  input wire prog_value,
  // State
  output reg quad_io_enable,
  output reg busy
);
  localparam CW = 24;
  reg [CW-1:0] count;
  reg pending;
  reg loaded;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      count <= 24'h000000;
      pending <= 1'b0;
      busy <= 1'b0;
      loaded <= 1'b0;
      quad_io_enable <= `FCS_QE_SHIPPED;
    end
    else
    begin
      if (!loaded)
      begin
        loaded <= 1'b1;
        quad_io_enable <= nv_init;
      end
      if (prog_start && !busy)
      begin
        busy <= 1'b1;
        pending <= prog_value;
        count <= WRCR_CYCLES[CW-1:0];
      end
      else if (busy)
      begin
        if (count <= 24'h000001)
        begin
          busy <= 1'b0;
          quad_io_enable <= pending;
        end
        else
          count <= count - 24'h000001;
      end
    end
  end
endmodule

// [logic/fcs_cmd.v]
// Command interpreter for configuration read, quad enable, active status, protection
// Assumes SPI mode 0/3 on sck and cs_n pins, both sampled by ref_clk (>= 4x sck)
`timescale 1ns/1ns
`include "fcs_regs.vh"
module fcs_cmd #(
  parameter WRCR_CYCLES = `FCS_WRCR_CYCLES,
  parameter NSECT = 32
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // SPI pins
  input wire cs_n,
  input wire sck,
  input wire si,
  output reg so,
  output reg so_oe_n,
  // Nonvolatile inputs
  input wire nv_quad_init,
  input wire [NSECT-1:0] nv_sector_marks,
  // Other internal operations of the device
  input wire array_busy,
  input wire op_request,
  input wire [4:0] op_sector,
  input wire quad_cmd_seen,
  // Results
  output reg quad_io_enable,
  output reg ready_busy_flag,
  output reg sw_protect_on,
  output reg op_refused,
  output reg quad_cmd_accept,
  output reg pins_as_data
);
  localparam ST_OPCODE = 3'h0;
  localparam ST_SEQ = 3'h1;
  localparam ST_CFG_OUT = 3'h2;
  localparam ST_STATUS = 3'h3;
  localparam ST_IGNORE = 3'h4;

  // Actions wait here until chip select rises on a clean frame
  localparam ACT_NONE = 2'h0;
  localparam ACT_QUAD_ON = 2'h1;
  localparam ACT_QUAD_OFF = 2'h2;
  localparam ACT_PROT_ON = 2'h3;

  wire cs_n_s;
  wire sck_s;
  wire si_s;
  wire qe;
  wire cfg_busy;
  reg sck_d;
  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg [1:0] byte_cnt;
  reg [7:0] shift;
  reg [7:0] seq_b3;
  reg [2:0] out_idx;
  reg prot_off_pend;
  reg [1:0] act_pend;
  reg prog_start;
  reg prog_value;
  reg [7:0] next_byte;

  // Decode the final byte of a four-byte 3Dh 2Ah sequence
  function [1:0] seq_action;
    input [7:0] b3;
    input [7:0] b4;
    begin
      seq_action = ACT_NONE;
      if (b3 == `FCS_SEQ_CFG && b4 == `FCS_SEQ_QUAD_ON)
        seq_action = ACT_QUAD_ON;
      else if (b3 == `FCS_SEQ_CFG && b4 == `FCS_SEQ_QUAD_OFF)
        seq_action = ACT_QUAD_OFF;
      else if (b3 == `FCS_SEQ_PROT && b4 == `FCS_SEQ_PROT_ON)
        seq_action = ACT_PROT_ON;
    end
  endfunction

  // Every input pin passes two flops; sck must hold each level for two ref_clk periods
  // Chip select resets high so no frame is seen while reset is released
  fcs_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(cs_n),
    .sync_out(cs_n_s)
  );
  fcs_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(sck),
    .sync_out(sck_s)
  );
  fcs_sync #(.RESET_VAL(1'b0)) u_sync_si (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(si),
    .sync_out(si_s)
  );

  fcs_nv_cfg #(.WRCR_CYCLES(WRCR_CYCLES)) u_nv (
    .ref_clk(ref_clk),
    .rst(rst),
    .nv_init(nv_quad_init),
    .prog_start(prog_start),
    .prog_value(prog_value),
    .quad_io_enable(qe),
    .busy(cfg_busy)
  );

  // Edges of the synchronised link clock, one ref_clk wide
  wire sck_rise = sck_s && !sck_d;
  wire sck_fall = !sck_s && sck_d;
  wire [7:0] cfg_byte = {qe, 7'h00} | `FCS_CFG_FIXED;

  always @*
  begin
    next_byte = {shift[6:0], si_s};
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sck_d <= 1'b0;
      state <= ST_OPCODE;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      shift <= 8'h00;
      seq_b3 <= 8'h00;
      out_idx <= 3'h7;
      act_pend <= ACT_NONE;
      prot_off_pend <= 1'b0;
      prog_start <= 1'b0;
      prog_value <= 1'b0;
      sw_protect_on <= 1'b0;
      so <= 1'b0;
      so_oe_n <= 1'b1;
      op_refused <= 1'b0;
      quad_cmd_accept <= 1'b0;
      pins_as_data <= 1'b0;
      quad_io_enable <= `FCS_QE_SHIPPED;
      ready_busy_flag <= 1'b1;
    end
    else
    begin
      sck_d <= sck_s;
      prog_start <= 1'b0;
      // Registered copies keep every output straight from a flop
      quad_io_enable <= qe;
      ready_busy_flag <= !(cfg_busy || array_busy);
      pins_as_data <= qe;
      quad_cmd_accept <= quad_cmd_seen && quad_io_enable;
      op_refused <= op_request && sw_protect_on && nv_sector_marks[op_sector];
      if (cs_n_s)
      begin
        // Deselect ends any frame and launches a completed sequence
        state <= ST_OPCODE;
        bit_cnt <= 3'h0;
        byte_cnt <= 2'h0;
        so_oe_n <= 1'b1;
        so <= 1'b0;
        act_pend <= ACT_NONE;
        prot_off_pend <= 1'b0;
        if (prot_off_pend)
          sw_protect_on <= 1'b0;
        case (act_pend)
          ACT_QUAD_ON:
          begin
            prog_start <= 1'b1;
            prog_value <= 1'b1;
          end
          ACT_QUAD_OFF:
          begin
            prog_start <= 1'b1;
            prog_value <= 1'b0;
          end
          ACT_PROT_ON:
            sw_protect_on <= 1'b1;
          default:
            prog_start <= 1'b0;
        endcase
      end
      else
      begin
        case (state)
          ST_OPCODE, ST_SEQ:
          begin
            if (sck_rise)
            begin
              shift <= next_byte;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
              begin
                byte_cnt <= byte_cnt + 2'h1;
                if (state == ST_OPCODE)
                begin
                  if (next_byte == `FCS_OP_READ_CFG)
                  begin
                    state <= ST_CFG_OUT;
                    out_idx <= 3'h7;
                  end
                  else if (next_byte == `FCS_OP_ACTIVE_STATUS)
                    state <= ST_STATUS;
                  else if (next_byte == `FCS_SEQ_B1)
                    state <= ST_SEQ;
                  else
                    state <= ST_IGNORE;
                end
                else if (byte_cnt == 2'h1 && next_byte != `FCS_SEQ_B2)
                  state <= ST_IGNORE;
                else if (byte_cnt == 2'h2)
                  seq_b3 <= next_byte;
                else if (byte_cnt == 2'h3)
                begin
                  act_pend <= seq_action(seq_b3, next_byte);
                  prot_off_pend <= (seq_b3 == `FCS_SEQ_PROT) &&
                                   (next_byte == `FCS_SEQ_PROT_OFF);
                  state <= ST_IGNORE;
                end
              end
            end
          end
          ST_CFG_OUT:
          begin
            // First bit leaves on the fall ending the opcode; the index wraps to repeat
            if (sck_fall)
            begin
              so_oe_n <= 1'b0;
              so <= cfg_byte[out_idx];
              out_idx <= out_idx - 3'h1;
            end
          end
          ST_STATUS:
          begin
            // Live busy state, no sck needed; the serial input is not looked at
            so_oe_n <= 1'b0;
            so <= !(cfg_busy || array_busy);
          end
          ST_IGNORE:
          begin
            // Extra clocks after a sequence void it
            if (sck_rise)
            begin
              act_pend <= ACT_NONE;
              prot_off_pend <= 1'b0;
            end
          end
          default:
            state <= ST_IGNORE;
        endcase
      end
    end
  end
endmodule

// [verification/fcs_cmd_checker.sv]
// Port checker for the command block
// Assumes one clock domain, bound to every fcs_cmd instance
`timescale 1ns/1ns
module fcs_cmd_checker #(
  parameter WRCR_CYCLES = 25,
  parameter NSECT = 32
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Inputs of the block
  input wire cs_n,
  input wire array_busy,
  input wire op_request,
  input wire [4:0] op_sector,
  input wire quad_cmd_seen,
  input wire [NSECT-1:0] nv_sector_marks,
  // Outputs of the block
  input wire so,
  input wire so_oe_n,
  input wire quad_io_enable,
  input wire ready_busy_flag,
  input wire sw_protect_on,
  input wire op_refused,
  input wire quad_cmd_accept,
  input wire pins_as_data
);
  reg [15:0] busy_cnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Busy time not caused by array operations
  always @(posedge ref_clk)
    if (rst || ready_busy_flag || array_busy)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= busy_cnt + 16'h0001;
  oe_idle_a: assert property (cs_n [*5] |-> so_oe_n)
    else $error("so driven with chip select high");
  accept_a: assert property (quad_cmd_accept == $past(quad_cmd_seen && quad_io_enable))
    else $error("quad accept wrong");
  pins_a: assert property ($stable(quad_io_enable) |-> pins_as_data == quad_io_enable)
    else $error("pin role wrong");
  refuse_a: assert property (op_refused == $past(op_request && sw_protect_on
    && nv_sector_marks[op_sector]))
    else $error("refusal wrong");
  rbf_busy_a: assert property (array_busy [*2] |-> !ready_busy_flag)
    else $error("ready shown while busy");
  wrcr_len_a: assert property (busy_cnt <= WRCR_CYCLES + 2)
    else $error("config program too long");
  prot_cs_a: assert property ($changed(sw_protect_on) |-> cs_n)
    else $error("protection changed in frame");
  qe_cs_a: assert property ($changed(quad_io_enable) |-> cs_n)
    else $error("quad enable changed in frame");
  cover property (op_refused);
  cover property (quad_cmd_accept);
  cover property (!so_oe_n && !so && !cs_n);
endmodule
bind fcs_cmd fcs_cmd_checker #(.WRCR_CYCLES(WRCR_CYCLES), .NSECT(NSECT)) i_chk (
  .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .array_busy(array_busy),
  .op_request(op_request), .op_sector(op_sector), .quad_cmd_seen(quad_cmd_seen),
  .nv_sector_marks(nv_sector_marks), .so(so), .so_oe_n(so_oe_n),
  .quad_io_enable(quad_io_enable), .ready_busy_flag(ready_busy_flag),
  .sw_protect_on(sw_protect_on), .op_refused(op_refused),
  .quad_cmd_accept(quad_cmd_accept), .pins_as_data(pins_as_data));

// [verification/fcs_spi_host.sv]
// SPI host model: mode 0 frames, 320 ns link clock, still between frames
// Assumes the device samples sck with its own unrelated clock
`timescale 1ns/1ns
module fcs_spi_host (
  // SPI pins
  output reg cs_n,
  output reg sck,
  output reg si,
  input wire so,
  input wire so_oe_n
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task start;
    begin
      #13 cs_n = 1'b0;
      #160;
    end
  endtask
  // n bits MSB first; so taken just before each fall; a floating line reads inverted
  task xfer(input [7:0] tx, input integer n, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 7; i > 7 - n; i = i - 1)
      begin
        si = tx[i];
        #160 sck = 1'b1;
        #160 rx[i] = so_oe_n ? ~so : so;
        sck = 1'b0;
      end
    end
  endtask
  // Mode 0 needs no dummy clock; released si shows the inverse
  task stop;
    begin
      #160 cs_n = 1'b1;
      si = ~si;
      #320;
    end
  endtask
endmodule

// [verification/flash_config_status_protect_cmds_test.sv]
// Self-checking bench for the command block with an SPI host model
// Assumes the checker is bound through its own file
`timescale 1ns/1ns
module flash_config_status_protect_cmds_test;
  reg ref_clk, rst, nv_quad_init, array_busy, op_request, quad_cmd_seen, seen;
  reg [31:0] nv_sector_marks, lfsr;
  reg [4:0] op_sector;
  reg [7:0] rx;
  wire cs_n, sck, si, so, so_oe_n, quad_io_enable, ready_busy_flag, sw_protect_on;
  wire op_refused, quad_cmd_accept, pins_as_data;
  integer n_mismatch, compares, cyc, k, p, j;
  fcs_cmd #(.WRCR_CYCLES(4), .NSECT(32)) i_dut (.ref_clk(ref_clk), .rst(rst),
    .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n),
    .nv_quad_init(nv_quad_init), .nv_sector_marks(nv_sector_marks),
    .array_busy(array_busy), .op_request(op_request), .op_sector(op_sector),
    .quad_cmd_seen(quad_cmd_seen), .quad_io_enable(quad_io_enable),
    .ready_busy_flag(ready_busy_flag), .sw_protect_on(sw_protect_on),
    .op_refused(op_refused), .quad_cmd_accept(quad_cmd_accept),
    .pins_as_data(pins_as_data));
  fcs_spi_host i_host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Configuration byte: quad enable on top, bit 3 fixed at one
  function [7:0] exp_cfg(input q);
    exp_cfg = {q, 7'h08};
  endfunction
  function [31:0] next_lfsr(input [31:0] v);
    next_lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (n_mismatch == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: timeout", $time);
      stop_test;
    end
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #2;
    end
  endtask
  task do_reset(input q);
    begin
      rst = 1'b1;
      nv_quad_init = q;
      tick(6);
      rst = 1'b0;
      tick(3);
    end
  endtask
  task cmd(input [31:0] w);
    begin
      i_host.start;
      for (k = 3; k >= 0; k = k - 1)
        i_host.xfer(w[8*k+7 -: 8], 8, rx);
      i_host.stop;
    end
  endtask
  task prog(input [31:0] w, input q);
    begin
      seen = 1'b0;
      // Busy starts while the host model is still winding down, so watch alongside
      fork
        cmd(w);
        for (p = 0; p < 300; p = p + 1)
        begin
          tick(1);
          if (ready_busy_flag === 1'b0)
            seen = 1'b1;
        end
      join
      chk(seen, 1);
      chk(ready_busy_flag, 1);
      chk(quad_io_enable, q);
      chk(pins_as_data, q);
    end
  endtask
  // Two full bytes, then a partial one cut short by chip select
  task rdcfg(input q);
    begin
      i_host.start;
      i_host.xfer(8'h3f, 8, rx);
      i_host.xfer(8'h00, 8, rx);
      chk(rx, exp_cfg(q));
      i_host.xfer(8'h00, 8, rx);
      chk(rx, exp_cfg(q));
      i_host.xfer(8'h00, 3, rx);
      i_host.stop;
      chk(so_oe_n, 1);
    end
  endtask
  task op(input [4:0] s, input e);
    begin
      op_sector = s;
      op_request = 1'b1;
      tick(1);
      op_request = 1'b0;
      chk(op_refused, e);
      tick(1);
    end
  endtask
  task qc(input e);
    begin
      quad_cmd_seen = 1'b1;
      tick(1);
      quad_cmd_seen = 1'b0;
      chk(quad_cmd_accept, e);
    end
  endtask
  initial
  begin
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    lfsr = 32'h24c4;
    array_busy = 1'b0;
    op_request = 1'b0;
    quad_cmd_seen = 1'b0;
    op_sector = 5'h00;
    nv_sector_marks = 32'h0000_0000;
    do_reset(1'b0);
    chk({quad_io_enable, ready_busy_flag, sw_protect_on, so_oe_n}, 4'h5);
    rdcfg(1'b0);
    qc(1'b0);
    prog(32'h3d2a_8166, 1'b1);
    rdcfg(1'b1);
    qc(1'b1);
    cmd(32'h3d2a_8155);
    tick(30);
    chk({quad_io_enable, ready_busy_flag}, 2'h3);
    i_host.start;
    i_host.xfer(8'h25, 8, rx);
    tick(8);
    chk({so_oe_n, so}, 2'h1);
    array_busy = 1'b1;
    tick(4);
    chk({so_oe_n, so, ready_busy_flag}, 3'h0);
    array_busy = 1'b0;
    i_host.stop;
    chk(so_oe_n, 1);
    lfsr = next_lfsr(lfsr);
    nv_sector_marks = lfsr | 32'h8000_0001;
    op(5'h1f, 1'b0);
    cmd(32'h3d2a_7fa9);
    tick(8);
    chk(sw_protect_on, 1);
    op(5'h00, 1'b1);
    for (j = 0; j < 12; j = j + 1)
    begin
      lfsr = next_lfsr(lfsr);
      op(lfsr[4:0], nv_sector_marks[lfsr[4:0]]);
    end
    cmd(32'h3d2a_7f55);
    tick(8);
    chk(sw_protect_on, 1);
    cmd(32'h3d2a_7f9a);
    tick(8);
    chk(sw_protect_on, 0);
    op(5'h00, 1'b0);
    cmd(32'h3d2a_7fa9);
    tick(8);
    do_reset(1'b1);
    chk({sw_protect_on, quad_io_enable}, 2'h1);
    rdcfg(1'b1);
    prog(32'h3d2a_8167, 1'b0);
    rdcfg(1'b0);
    stop_test;
  end
endmodule
